// >>> verilog/srs_defines.svh
// offsets, field positions, reset values and read constants of the result/status register bank
// Notes on behaviour
// - low byte of newest conversion result reads at offset 0x00, read-only
// - high byte of newest conversion result reads at offset 0x01, read-only
// - both result bytes read zero after power-up until first conversion finishes
// - status at offset 0x02 resets to 0x3c; bits 5:4 always read ones
// - status bit 0 sets once configuration store is locked; config writes then refused
// - status bit 1 sets after address sent in discovery; clears when mode bits clear
// - status bit 2 shows supply: 0 dedicated, 1 bus powered; the sample after reset always gives 0, re-sampled each bus reset
// - alert flags update on each new result and clear on a status read
// - latched alert mode keeps a set alert flag until a status read
// - status bit 7 is one when result is at or above the high limit
// - status bit 6 is one when result is at or below the low limit
// - pin two in alert function shows the high and low alert flags
// - status bit 3 sets on each conversion update and clears on status read
// - config one at 0x04 resets 0x70, restored from store, saved by copy command
// - config one picks one-shot/auto/staggered on bus power, one-shot/periodic otherwise
// - config one bit 4: zero latched alert, one comparator; dedicated supply only
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

`define SRS_OFF_RES_LO      8'h00
`define SRS_OFF_RES_HI      8'h01
`define SRS_OFF_STATUS      8'h02
`define SRS_OFF_CFG1        8'h04

`define SRS_STATUS_RST      8'h3c
`define SRS_CFG1_RST        8'h70
`define SRS_RESULT_RST      16'h0000
`define SRS_UNMAPPED_READ   8'hff

`define SRS_ST_ALERT_HI     7
`define SRS_ST_ALERT_LO     6
`define SRS_ST_FRESH        3
`define SRS_ST_POWER        2
`define SRS_ST_DISCOVERY    1
`define SRS_ST_LOCK         0
`define SRS_ST_RSVD_VAL     2'h3

`define SRS_CFG1_ALERT_MODE 4
`define SRS_CFG1_MODE_LSB   0
`define SRS_CFG1_MODE_W     3

`endif

// >>> verilog/srs_pkg.sv
// types shared by the result/status register bank
package srs_pkg;
  // conversion scheduling selected by config one
  typedef enum logic [2:0] {
    srs_conv_one_shot,
    srs_conv_staggered,
    srs_conv_auto,
    srs_conv_periodic,
    srs_conv_unspecified
  } srs_conv_t;
endpackage

// >>> verilog/srs_sync.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module srs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,    // system clock
  input  wire logic             rst_n_in,  // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // level from outside the clock domain
  output logic      [WIDTH-1:0] sync_out   // level safe to read
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second stage
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// >>> verilog/srs_regs.sv
// result, status and config one registers of the temperature sensor scratchpad
`timescale 1ns/1ps
`include "srs_defines.svh"
module srs_regs #(
  parameter int MODE_BITS_W = 2
) (
  input  wire logic                   clk_in,                 // 40 mhz system clock
  input  wire logic                   rst_n_in,               // synchronous reset, active low
  input  wire logic                   rd_en_in,               // scratchpad read strobe
  input  wire logic [7:0]             rd_addr_in,             // scratchpad read offset
  output logic      [7:0]             rd_data_out,            // read byte, one cycle later
  input  wire logic                   wr_en_in,               // scratchpad write strobe
  input  wire logic [7:0]             wr_addr_in,             // scratchpad write offset
  input  wire logic [7:0]             wr_data_in,             // scratchpad write byte
  input  wire logic                   conv_done_in,           // conversion finished pulse
  input  wire logic [15:0]            conv_result_in,         // signed conversion result
  input  wire logic [15:0]            alert_high_limit_in,    // signed high limit
  input  wire logic [15:0]            alert_low_limit_in,     // signed low limit
  input  wire logic                   config_locked_in,       // config store lock reached
  input  wire logic                   addr_sent_ok_in,        // discovery address sent pulse
  input  wire logic [MODE_BITS_W-1:0] discovery_mode_bits_in, // discovery mode from config two
  input  wire logic                   bus_reset_in,           // bus reset detected pulse
  input  wire logic                   bus_powered_pin_in,     // supply sense pin, async
  input  wire logic                   store_load_in,          // power-on restore pulse
  input  wire logic [7:0]             store_cfg1_in,          // config one from store
  input  wire logic                   copy_cmd_in,            // copy scratchpad command pulse
  input  wire logic                   pin_two_alert_sel_in,   // pin two set to alert function
  output logic                        store_save_out,         // save config one pulse
  output logic      [7:0]             store_save_data_out,    // config one to save
  output logic      [7:0]             device_config_one_out,  // config one contents
  output srs_pkg::srs_conv_t          conv_mode_out,          // decoded conversion scheduling
  output logic                        general_pin_two_out,    // pin two level, driven low
  output logic                        general_pin_two_oe_out  // pin two enable, high drives
);
  logic        pwr_sync;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic        alert_hi_reg;
  logic        alert_hi_next;
  logic        alert_lo_reg;
  logic        alert_lo_next;
  logic        fresh_result_flag_reg;
  logic        fresh_result_flag_next;
  logic        power_reg;
  logic        power_next;
  logic        power_init_reg;
  logic        power_init_next;
  logic        discovery_finished_flag_reg;
  logic        discovery_finished_flag_next;
  logic        lock_reg;
  logic        lock_next;
  logic [7:0]  cfg1_reg;
  logic [7:0]  cfg1_next;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic        save_reg;
  logic        save_next;
  logic [7:0]  save_data_reg;
  logic [7:0]  save_data_next;
  logic        pin_oe_reg;
  logic        pin_oe_next;
  srs_pkg::srs_conv_t mode_reg;
  srs_pkg::srs_conv_t mode_next;
  logic        status_read;
  logic        hi_hit;
  logic        lo_hit;
  logic        latched_mode;
  logic [7:0]  status_byte;

  // reset pattern of the status byte; a literal cannot be bit-selected directly
  localparam logic [7:0] status_rst_val = `SRS_STATUS_RST;

  // supply sense comes from a pin, so it is synchronised first
  srs_sync #(
    .WIDTH (1)
  ) u_pwr_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (bus_powered_pin_in),
    .sync_out (pwr_sync)
  );

  // decode of the status read and the limit compares
  always_comb
  begin
    status_read  = rd_en_in && (rd_addr_in == `SRS_OFF_STATUS);
    hi_hit       = $signed(conv_result_in) >= $signed(alert_high_limit_in);
    lo_hit       = $signed(conv_result_in) <= $signed(alert_low_limit_in);
    latched_mode = !cfg1_reg[`SRS_CFG1_ALERT_MODE] && !power_reg;
    status_byte  = {alert_hi_reg, alert_lo_reg, `SRS_ST_RSVD_VAL, fresh_result_flag_reg,
                    power_reg, discovery_finished_flag_reg, lock_reg};
  end

  // result bytes and status flags
  always_comb
  begin
    result_next                  = result_reg;
    alert_hi_next                = alert_hi_reg;
    alert_lo_next                = alert_lo_reg;
    fresh_result_flag_next       = fresh_result_flag_reg;
    power_next                   = power_reg;
    power_init_next              = 1'b0;
    discovery_finished_flag_next = discovery_finished_flag_reg;
    lock_next                    = lock_reg;
    if (status_read)
    begin
      alert_hi_next          = 1'b0;
      alert_lo_next          = 1'b0;
      fresh_result_flag_next = 1'b0;
    end
    // a conversion in the same cycle as the read wins, so no result is missed
    if (conv_done_in)
    begin
      // result held until a conversion lands
      result_next            = conv_result_in;
      fresh_result_flag_next = 1'b1;
      if (latched_mode)
      begin
        alert_hi_next = alert_hi_reg || hi_hit;
        alert_lo_next = alert_lo_reg || lo_hit;
      end
      else
      begin
        alert_hi_next = hi_hit;
        alert_lo_next = lo_hit;
      end
    end
    // supply flag loaded after reset from the synchroniser's reset zero, and sampled per bus reset
    if (power_init_reg || bus_reset_in)
    begin
      power_next = pwr_sync;
    end
    // discovery flag clears with its mode bits
    if (discovery_mode_bits_in == '0)
    begin
      discovery_finished_flag_next = 1'b0;
    end
    if (addr_sent_ok_in)
    begin
      discovery_finished_flag_next = 1'b1;
    end
    if (config_locked_in)
    begin
      lock_next = 1'b1;
    end
  end

  // config one, store traffic and read port
  always_comb
  begin
    cfg1_next      = cfg1_reg;
    save_next      = 1'b0;
    save_data_next = save_data_reg;
    rd_data_next   = rd_data_reg;
    if (store_load_in)
    begin
      cfg1_next = store_cfg1_in;
    end
    else if (wr_en_in && (wr_addr_in == `SRS_OFF_CFG1) && !lock_reg)
    begin
      cfg1_next = wr_data_in;
    end
    if (copy_cmd_in)
    begin
      save_next      = 1'b1;
      save_data_next = cfg1_reg;
    end
    if (rd_en_in)
    begin
      unique case (rd_addr_in)
        `SRS_OFF_RES_LO: rd_data_next = result_reg[7:0];
        `SRS_OFF_RES_HI: rd_data_next = result_reg[15:8];
        `SRS_OFF_STATUS: rd_data_next = status_byte;
        `SRS_OFF_CFG1:   rd_data_next = cfg1_reg;
        default:         rd_data_next = `SRS_UNMAPPED_READ;
      endcase
    end
  end

  // conversion scheduling decode and alert pin
  always_comb
  begin
    if (power_reg)
    begin
      unique case (cfg1_reg[`SRS_CFG1_MODE_LSB +: `SRS_CFG1_MODE_W])
        3'h0:    mode_next = srs_pkg::srs_conv_one_shot;
        3'h1:    mode_next = srs_pkg::srs_conv_staggered;
        3'h2:    mode_next = srs_pkg::srs_conv_auto;
        default: mode_next = srs_pkg::srs_conv_unspecified;
      endcase
    end
    else if (cfg1_reg[`SRS_CFG1_MODE_LSB +: `SRS_CFG1_MODE_W] == 3'h0)
    begin
      mode_next = srs_pkg::srs_conv_one_shot;
    end
    else
    begin
      mode_next = srs_pkg::srs_conv_periodic;
    end
    // pin two pulled low on any alert while pin two is set to alert function
    pin_oe_next = pin_two_alert_sel_in && (alert_hi_reg || alert_lo_reg);
  end

  // power flag resets to one so status reads 0x3c before the first sample
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      result_reg                  <= `SRS_RESULT_RST;
      alert_hi_reg                <= status_rst_val[`SRS_ST_ALERT_HI];
      alert_lo_reg                <= status_rst_val[`SRS_ST_ALERT_LO];
      fresh_result_flag_reg       <= status_rst_val[`SRS_ST_FRESH];
      power_reg                   <= status_rst_val[`SRS_ST_POWER];
      power_init_reg              <= 1'b1;
      discovery_finished_flag_reg <= status_rst_val[`SRS_ST_DISCOVERY];
      lock_reg                    <= status_rst_val[`SRS_ST_LOCK];
      cfg1_reg                    <= `SRS_CFG1_RST;
      save_reg                    <= 1'b0;
      save_data_reg               <= `SRS_CFG1_RST;
      rd_data_reg                 <= 8'h00;
      mode_reg                    <= srs_pkg::srs_conv_one_shot;
      pin_oe_reg                  <= 1'b0;
    end
    else
    begin
      result_reg                  <= result_next;
      alert_hi_reg                <= alert_hi_next;
      alert_lo_reg                <= alert_lo_next;
      fresh_result_flag_reg       <= fresh_result_flag_next;
      power_reg                   <= power_next;
      power_init_reg              <= power_init_next;
      discovery_finished_flag_reg <= discovery_finished_flag_next;
      lock_reg                    <= lock_next;
      cfg1_reg                    <= cfg1_next;
      save_reg                    <= save_next;
      save_data_reg               <= save_data_next;
      rd_data_reg                 <= rd_data_next;
      mode_reg                    <= mode_next;
      pin_oe_reg                  <= pin_oe_next;
    end
  end

  // open-drain pin only ever drives low
  assign general_pin_two_out    = 1'b0;
  assign general_pin_two_oe_out = pin_oe_reg;
  assign rd_data_out            = rd_data_reg;
  assign store_save_out         = save_reg;
  assign store_save_data_out    = save_data_reg;
  assign device_config_one_out  = cfg1_reg;
  assign conv_mode_out          = mode_reg;

  // checks on the bank's own behaviour
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_result_low_read: assert property (rd_en_in && rd_addr_in == `SRS_OFF_RES_LO && !conv_done_in
    |=> rd_data_out == $past(result_reg[7:0]) && result_reg == $past(result_reg))
    else $error("low result byte read wrong");
  a_result_high_load: assert property (conv_done_in |=> result_reg[15:8] == $past(conv_result_in[15:8]))
    else $error("high result byte not loaded");
  a_result_hold: assert property (!conv_done_in |=> $stable(result_reg))
    else $error("result changed without conversion");
  a_status_reserved: assert property (rd_en_in && rd_addr_in == `SRS_OFF_STATUS
    |=> rd_data_out[5:4] == 2'h3)
    else $error("reserved status bits not ones");
  a_lock_refuses: assert property (lock_reg && !store_load_in
    |=> cfg1_reg == $past(cfg1_reg))
    else $error("config one changed while locked");
  a_discovery_clear: assert property (discovery_mode_bits_in == '0 && !addr_sent_ok_in
    |=> !discovery_finished_flag_reg)
    else $error("discovery flag not cleared");
  a_power_sample: assert property (bus_reset_in |=> power_reg == $past(pwr_sync))
    else $error("supply flag not sampled on bus reset");
  a_read_clears: assert property (status_read && !conv_done_in
    |=> !alert_hi_reg && !alert_lo_reg && !fresh_result_flag_reg)
    else $error("status read did not clear flags");
  a_latched_hold: assert property (latched_mode && alert_hi_reg && !status_read
    |=> alert_hi_reg)
    else $error("latched alert dropped");
  a_high_compare: assert property (conv_done_in && !latched_mode
    |=> alert_hi_reg == $past(hi_hit))
    else $error("high alert flag wrong");
  a_low_compare: assert property (conv_done_in && !latched_mode
    |=> alert_lo_reg == $past(lo_hit))
    else $error("low alert flag wrong");
  a_pin_alert: assert property (pin_two_alert_sel_in && (alert_hi_reg || alert_lo_reg)
    |=> general_pin_two_oe_out)
    else $error("pin two not driven on alert");
  a_fresh_set: assert property (conv_done_in |=> fresh_result_flag_reg ##1 1'b1)
    else $error("fresh flag not set");
  a_copy_save: assert property (copy_cmd_in |=> store_save_out && store_save_data_out == $past(cfg1_reg))
    else $error("copy did not save config one");

  c_conversion: cover property (conv_done_in ##1 status_read);
  c_read_race: cover property (status_read && conv_done_in);
  c_lock_write: cover property (lock_reg && wr_en_in && wr_addr_in == `SRS_OFF_CFG1);
  c_latched_alert: cover property (latched_mode && alert_hi_reg ##1 alert_hi_reg);
endmodule

// >>> verif/srs_host_model.sv
// host-side model of the single-wire scratchpad access to the result/status bank
`timescale 1ns/1ps
module srs_host_model (
  input  wire logic       clk_in,      // system clock
  output logic            rd_en_out,   // scratchpad read strobe
  output logic [7:0]      rd_addr_out, // scratchpad read offset
  input  wire logic [7:0] rd_data_in,  // byte returned by the bank
  output logic            wr_en_out,   // scratchpad write strobe
  output logic [7:0]      wr_addr_out, // scratchpad write offset
  output logic [7:0]      wr_data_out  // scratchpad write byte
);
  // idle bus at time zero
  initial
  begin
    rd_en_out   = 1'b0;
    rd_addr_out = 8'hff;
    wr_en_out   = 1'b0;
    wr_addr_out = 8'hff;
    wr_data_out = 8'h00;
  end

  // scratchpad read access
  // a status read clears alert and fresh flags unless a conversion lands in the same cycle, so callers must plan for it
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_in);
    rd_en_out   <= 1'b1;
    rd_addr_out <= addr;
    @(posedge clk_in);
    rd_en_out   <= 1'b0;
    rd_addr_out <= ~addr; // offset no longer meaningful once taken
    // byte stands from the taking edge until the next read, so take it at the next edge
    @(posedge clk_in);
    data = rd_data_in;
  endtask

  // single byte write, held for the one taking edge
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    wr_en_out   <= 1'b1;
    wr_addr_out <= addr;
    wr_data_out <= data;
    @(posedge clk_in);
    wr_en_out   <= 1'b0;
    wr_addr_out <= ~addr;
    wr_data_out <= ~data; // stale data never looks like a valid byte
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the result/status register bank
`timescale 1ns/1ps
module testbench;
  logic                rst_n_in = 1'b0;
  logic                clk_in   = 1'b0;
  logic                rd_en, wr_en;
  logic [7:0]          rd_addr, rd_data, wr_addr, wr_data, cfg1, save_data, got;
  logic                conv_done = 1'b0, locked = 1'b0, addr_ok = 1'b0, bus_rst = 1'b0;
  logic                pwr_pin = 1'b0, load = 1'b0, copy = 1'b0, sel = 1'b1;
  logic [15:0]         result = 16'h0000, hi_lim = 16'h7fff, lo_lim = 16'h8000;
  logic [7:0]          store_val = 8'h00;
  logic [1:0]          mode_bits = 2'h0;
  logic                save, pin_lvl, pin_oe;
  srs_pkg::srs_conv_t  conv_mode;
  int                  fail_count = 0;
  int                  tests_run = 0;
  int                  cycles = 0;

  // 40 mhz clock
  always #12.5 clk_in = ~clk_in;

  srs_regs uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
    .rd_data_out(rd_data), .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
    .conv_done_in(conv_done), .conv_result_in(result), .alert_high_limit_in(hi_lim),
    .alert_low_limit_in(lo_lim), .config_locked_in(locked), .addr_sent_ok_in(addr_ok),
    .discovery_mode_bits_in(mode_bits), .bus_reset_in(bus_rst), .bus_powered_pin_in(pwr_pin),
    .store_load_in(load), .store_cfg1_in(store_val), .copy_cmd_in(copy),
    .pin_two_alert_sel_in(sel), .store_save_out(save), .store_save_data_out(save_data),
    .device_config_one_out(cfg1), .conv_mode_out(conv_mode), .general_pin_two_out(pin_lvl),
    .general_pin_two_oe_out(pin_oe));

  srs_host_model host (.clk_in(clk_in), .rd_en_out(rd_en), .rd_addr_out(rd_addr),
    .rd_data_in(rd_data), .wr_en_out(wr_en), .wr_addr_out(wr_addr), .wr_data_out(wr_data));

  // counts and verdict, the single exit point
  task automatic close_out;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
    tests_run++;
    if (got_v !== exp_v)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp_v);
    host.read_byte(addr, got);
    check(got, exp_v);
  endtask

  // one conversion pulse carrying a result
  task automatic conv(input logic [15:0] r);
    @(posedge clk_in);
    conv_done <= 1'b1;
    result    <= r;
    @(posedge clk_in);
    conv_done <= 1'b0;
  endtask

  task automatic t_reset;
    host.write_byte(8'h00, 8'haa);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h38);
    rd_chk(8'h02, 8'h30);
    rd_chk(8'h04, 8'h70);
    rd_chk(8'h03, 8'hff);
    check({5'h00, conv_mode}, {5'h00, srs_pkg::srs_conv_one_shot});
    $display("reset values done");
  endtask

  task automatic t_conv;
    conv(16'h1234);
    rd_chk(8'h00, 8'h34);
    rd_chk(8'h01, 8'h12);
    rd_chk(8'h02, 8'h38);
    rd_chk(8'h02, 8'h30);
    $display("conversion result done");
  endtask

  // latched mode keeps the high flag after a return inside limits
  task automatic t_latched;
    host.write_byte(8'h04, 8'h60);
    rd_chk(8'h04, 8'h60);
    hi_lim <= 16'h0100;
    lo_lim <= 16'hff00;
    conv(16'h0100);
    @(posedge clk_in);
    #1;
    check({7'h00, pin_oe}, 8'h01);
    check({7'h00, pin_lvl}, 8'h00);
    conv(16'h0050);
    rd_chk(8'h02, 8'hb8);
    rd_chk(8'h02, 8'h30);
    @(posedge clk_in);
    #1;
    check({7'h00, pin_oe}, 8'h00);
    $display("latched alert done");
  endtask

  // comparator mode follows each result, low limit inclusive
  task automatic t_comparator;
    host.write_byte(8'h04, 8'h70);
    conv(16'hff00);
    conv(16'h0000);
    rd_chk(8'h02, 8'h38);
    // pin two not in alert function: a low alert must leave it released
    sel <= 1'b0;
    conv(16'hff00);
    repeat (2) @(posedge clk_in);
    check({7'h00, pin_oe}, 8'h00);
    sel <= 1'b1;
    rd_chk(8'h02, 8'h78);
    conv(16'hff01);
    rd_chk(8'h02, 8'h38);
    $display("comparator alert done");
  endtask

  task automatic t_discovery;
    mode_bits <= 2'h1;
    @(posedge clk_in);
    addr_ok <= 1'b1;
    @(posedge clk_in);
    addr_ok <= 1'b0;
    rd_chk(8'h02, 8'h32);
    rd_chk(8'h02, 8'h32);
    mode_bits <= 2'h0;
    rd_chk(8'h02, 8'h30);
    $display("discovery flag done");
  endtask

  task automatic t_lock_store;
    store_val <= 8'h55;
    load      <= 1'b1;
    @(posedge clk_in);
    load <= 1'b0;
    rd_chk(8'h04, 8'h55);
    check(cfg1, 8'h55);
    check({5'h00, conv_mode}, {5'h00, srs_pkg::srs_conv_periodic});
    copy <= 1'b1;
    @(posedge clk_in);
    copy <= 1'b0;
    #1;
    check({7'h00, save}, 8'h01);
    check(save_data, 8'h55);
    @(posedge clk_in);
    locked <= 1'b1;
    #1;
    check({7'h00, save}, 8'h00);
    host.write_byte(8'h04, 8'h11);
    rd_chk(8'h04, 8'h55);
    check(cfg1, 8'h55);
    rd_chk(8'h02, 8'h31);
    $display("lock and store done");
  endtask

  task automatic t_supply;
    pwr_pin <= 1'b1;
    repeat (4) @(posedge clk_in);
    bus_rst <= 1'b1;
    @(posedge clk_in);
    bus_rst <= 1'b0;
    rd_chk(8'h02, 8'h35);
    @(posedge clk_in);
    check({5'h00, conv_mode}, {5'h00, srs_pkg::srs_conv_unspecified});
    $display("supply sense done");
  endtask

  // reset in mid-run must bring result, status and config one back
  task automatic t_rerst;
    rst_n_in <= 1'b0;
    locked   <= 1'b0;
    pwr_pin  <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h02, 8'h38);
    rd_chk(8'h04, 8'h70);
    check(cfg1, 8'h70);
    $display("mid-run reset done");
  endtask

  // hang guard, generous against a run of about 125 cycles
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_conv();
    t_latched();
    t_comparator();
    t_discovery();
    t_lock_store();
    t_supply();
    t_rerst();
    close_out();
  end
endmodule
